//--- hw/tscr_regs.sv
// touch sensor control and status register bank behind an i2c port
`timescale 1ns/10ps
module tscr_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // value is arbitrary
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] touch_raw,
  output tscr_pkg::tscr_levels_t sens_levels,
  output tscr_pkg::tscr_mode_t scan_mode,
  output logic [7:0] ref_renew,
  output logic [7:0] ref_renew_strobe,
  output logic [7:0] channel_suspend,
  output logic [7:0] touch_result_low,
  output logic digital_reset
);
  tscr_pkg::tscr_wr_t wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic rst_core_n;
  logic soft_rst_r;
  logic [7:0] sens45_r;
  logic [7:0] sens67_r;
  logic [7:0] general_control_one_r;
  logic [7:0] general_control_two_r;
  logic [7:0] refr_r;
  logic [7:0] strobe_r;
  logic [7:0] susp_r;
  logic [7:0] result_r;
  logic [3:0] touch_m_r;
  logic [3:0] touch_s_r;
  logic wr_sens45;
  logic wr_sens67;
  logic wr_general_control_one;
  logic wr_general_control_two;
  logic wr_refr;
  logic wr_susp;
  tscr_pkg::tscr_mode_t mode_r;
  logic dreset_r;

  function automatic logic hit(input tscr_pkg::tscr_wr_t w,
                               input logic [7:0] ofs);
    hit = w.wr && (w.addr == ofs);
  endfunction

  // ==========================================================
  // write decode; the result offset has no strobe, so host
  // writes there fall away
  assign wr_sens45 = hit(wr, tscr_pkg::OFS_SENS45);
  assign wr_sens67 = hit(wr, tscr_pkg::OFS_SENS67);
  assign wr_general_control_one = hit(wr, tscr_pkg::OFS_GENERAL_CONTROL_ONE);
  assign wr_general_control_two = hit(wr, tscr_pkg::OFS_GENERAL_CONTROL_TWO);
  assign wr_refr = hit(wr, tscr_pkg::OFS_REFR);
  assign wr_susp = hit(wr, tscr_pkg::OFS_SUSP);

  // ==========================================================
  // reset: software reset reaches every flop here but soft_rst_r and dreset_r, and the i2c port
  // the pulse lasts one cycle; every reset here is synchronous
  assign rst_core_n = nrst & ~soft_rst_r;

  // one-cycle pulse, cleared by itself so a read back shows zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_general_control_two &&
                    wr.data[tscr_pkg::SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dreset_r <= 1'b1;
    end else begin
      dreset_r <= soft_rst_r;
    end
  end

  // ==========================================================
  // i2c port
  tscr_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_i2c (
    .clk(clk),
    .rst_n(rst_core_n),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr_req(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ==========================================================
  // sensitivity levels; reserved bits are dropped on write
  always_ff @(posedge clk) begin
    if (!rst_core_n) begin
      sens45_r <= tscr_pkg::RST_SENS;
      sens67_r <= tscr_pkg::RST_SENS;
    end else begin
      if (wr_sens45) begin
        sens45_r <= wr.data & tscr_pkg::MASK_SENS;
      end
      if (wr_sens67) begin
        sens67_r <= wr.data & tscr_pkg::MASK_SENS;
      end
    end
  end

  // ==========================================================
  // general control
  always_ff @(posedge clk) begin
    if (!rst_core_n) begin
      general_control_one_r <= tscr_pkg::RST_GENERAL_CONTROL_ONE;
      general_control_two_r <= tscr_pkg::RST_GENERAL_CONTROL_TWO;
    end else begin
      if (wr_general_control_one) begin
        general_control_one_r <= wr.data & tscr_pkg::MASK_GENERAL_CONTROL_ONE;
      end
      if (wr_general_control_two) begin
        // soft reset bit is not stored, it is never read back as one
        general_control_two_r <= wr.data & tscr_pkg::MASK_GENERAL_CONTROL_TWO;
      end
    end
  end

  // scan mode decided from speed select and sleep enable
  always_ff @(posedge clk) begin
    if (!rst_core_n) begin
      mode_r <= '0;
    end else begin
      mode_r.speed_select <= general_control_one_r[tscr_pkg::SPEED_SELECT_BIT];
      mode_r.sleep_enable <= general_control_two_r[tscr_pkg::SLEEP_BIT];
      mode_r.sleep_run <= ~general_control_one_r[tscr_pkg::SPEED_SELECT_BIT] &
                          general_control_two_r[tscr_pkg::SLEEP_BIT];
      mode_r.fast_run <= general_control_one_r[tscr_pkg::SPEED_SELECT_BIT];
    end
  end

  // ==========================================================
  // reference renewal: level held plus a strobe per written one
  // the level is for read back; the strobe starts the renewal
  always_ff @(posedge clk) begin
    if (!rst_core_n) begin
      refr_r <= tscr_pkg::RST_REFR;
      strobe_r <= tscr_pkg::RST_REFR;
    end else begin
      strobe_r <= tscr_pkg::RST_REFR;
      if (wr_refr) begin
        refr_r <= wr.data;
        strobe_r <= wr.data;
      end
    end
  end

  // ==========================================================
  // channel suspend
  always_ff @(posedge clk) begin
    if (!rst_core_n) begin
      susp_r <= tscr_pkg::RST_SUSP;
    end else if (wr_susp) begin
      susp_r <= wr.data;
    end
  end

  // ==========================================================
  // touch results; raw detector levels come from another domain
  // each bit is a lone level, so a plain two-flop chain is enough
  always_ff @(posedge clk) begin
    if (!rst_core_n) begin
      touch_m_r <= 4'h0;
      touch_s_r <= 4'h0;
    end else begin
      touch_m_r <= touch_raw;
      touch_s_r <= touch_m_r;
    end
  end

  // a suspended channel keeps its last result instead of sensing;
  // host writes never reach this register
  always_ff @(posedge clk) begin
    if (!rst_core_n) begin
      result_r <= tscr_pkg::RST_RESULT;
    end else begin
      for (int i = 0; i < tscr_pkg::RESULT_CH; i++) begin
        if (!susp_r[i]) begin
          result_r[2*i +: 2] <= touch_s_r[i] ? tscr_pkg::RES_TOUCHED
                                : tscr_pkg::RES_NOT_TOUCHED;
        end
      end
    end
  end

  // ==========================================================
  // read decode; unmapped offsets read as zero
  always_comb begin
    case (rd_addr)
      tscr_pkg::OFS_SENS45: rd_data = sens45_r;
      tscr_pkg::OFS_SENS67: rd_data = sens67_r;
      tscr_pkg::OFS_GENERAL_CONTROL_ONE: rd_data = general_control_one_r;
      tscr_pkg::OFS_GENERAL_CONTROL_TWO: rd_data = general_control_two_r;
      tscr_pkg::OFS_REFR: rd_data = refr_r;
      tscr_pkg::OFS_SUSP: rd_data = susp_r;
      tscr_pkg::OFS_RESULT: rd_data = result_r;
      default: rd_data = tscr_pkg::READ_UNMAPPED;
    endcase
  end

  // ==========================================================
  // outputs
  assign sens_levels.ch7 = sens67_r[tscr_pkg::SENS_HI_LSB +: 3];
  assign sens_levels.ch6 = sens67_r[tscr_pkg::SENS_LO_LSB +: 3];
  assign sens_levels.ch5 = sens45_r[tscr_pkg::SENS_HI_LSB +: 3];
  assign sens_levels.ch4 = sens45_r[tscr_pkg::SENS_LO_LSB +: 3];
  assign scan_mode = mode_r;
  assign ref_renew = refr_r;
  assign ref_renew_strobe = strobe_r;
  assign channel_suspend = susp_r;
  assign touch_result_low = result_r;
  assign digital_reset = dreset_r;
endmodule

//--- hw/tscr_pkg.sv
// constants and carrier types of the touch sensor control register bank
// ==========================================================
// What this block does
// - level 000 most sensitive, 111 least, 011 default
// - offset 05h holds ch7 6:4, ch6 2:0, reset 0x33
// - channels 4/5 level register, resets to 0x33
// - bit 7 at 06h selects fast-only, reset 0x80
// - speed clear plus sleep runs sleep; set runs continuous
// - software reset clears all digital logic but soft_rst_r and dreset_r, and I2C
// - bit 2 at 07h enables low-power sleep sensing
// - bit x at 08h renews channel x reference
// - bit x at 09h suspends channel x sensing
// - 0Ah reports two result bits per channel 0-3
package tscr_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_SENS45 = 8'h04;
  localparam logic [7:0] OFS_SENS67 = 8'h05;
  localparam logic [7:0] OFS_GENERAL_CONTROL_ONE = 8'h06;
  localparam logic [7:0] OFS_GENERAL_CONTROL_TWO = 8'h07;
  localparam logic [7:0] OFS_REFR = 8'h08;
  localparam logic [7:0] OFS_SUSP = 8'h09;
  localparam logic [7:0] OFS_RESULT = 8'h0A;

  // ==========================================================
  // reset values and writable masks
  localparam logic [7:0] RST_SENS = 8'h33;
  localparam logic [7:0] RST_GENERAL_CONTROL_ONE = 8'h80;
  localparam logic [7:0] RST_GENERAL_CONTROL_TWO = 8'h00;
  localparam logic [7:0] RST_REFR = 8'h00;
  localparam logic [7:0] RST_SUSP = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] MASK_SENS = 8'h77;
  localparam logic [7:0] MASK_GENERAL_CONTROL_ONE = 8'h80;
  localparam logic [7:0] MASK_GENERAL_CONTROL_TWO = 8'h04;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ==========================================================
  // field positions
  localparam int SENS_HI_LSB = 4;
  localparam int SENS_LO_LSB = 0;
  localparam int SPEED_SELECT_BIT = 7;
  localparam int SOFT_RESET_BIT = 3;
  localparam int SLEEP_BIT = 2;
  localparam int RESULT_CH = 4;

  // ==========================================================
  // encodings
  localparam logic [2:0] LEVEL_HIGHEST = 3'h0;
  localparam logic [2:0] LEVEL_NORMAL = 3'h3;
  localparam logic [2:0] LEVEL_LOWEST = 3'h7;
  localparam logic [1:0] RES_NOT_TOUCHED = 2'h0;
  localparam logic [1:0] RES_TOUCHED = 2'h3;

  // ==========================================================
  // i2c framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_MSB = 4'h7;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } tscr_wr_t;

  typedef struct packed {
    logic [2:0] ch7;
    logic [2:0] ch6;
    logic [2:0] ch5;
    logic [2:0] ch4;
  } tscr_levels_t;

  typedef struct packed {
    logic speed_select;
    logic sleep_enable;
    logic sleep_run;
    logic fast_run;
  } tscr_mode_t;
endpackage

//--- hw/tscr_i2c_slave.sv
// i2c slave that turns bus transfers into register writes and reads
`timescale 1ns/10ps
module tscr_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // value is arbitrary
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output tscr_pkg::tscr_wr_t wr_req,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ,
    ST_READ_ACK
  } tscr_i2c_st_t;

  tscr_i2c_st_t state_r;
  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic [3:0] cnt_r;
  logic rw_r, first_r, nack_r;
  logic sda_out_r, sda_oe_r;
  tscr_pkg::tscr_wr_t wr_r;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  // ==========================================================
  // pin synchronisers; the second and third stages are looked at
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_m_r <= scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign start_seen = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_seen = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ==========================================================
  // byte engine: sample on scl rise, drive on scl fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      cnt_r <= 4'h0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      wr_r <= '0;
    end else begin
      wr_r.wr <= 1'b0;
      if (start_seen) begin
        state_r <= ST_ADDR;
        cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (stop_seen) begin
        state_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else if (scl_rise) begin
        if (state_r == ST_ADDR || state_r == ST_WRITE) begin
          shift_r <= {shift_r[6:0], sda_s_r};
        end
        if (state_r == ST_ADDR || state_r == ST_WRITE ||
            state_r == ST_READ) begin
          cnt_r <= cnt_r + 4'h1;
        end
        if (state_r == ST_READ_ACK) begin
          nack_r <= sda_s_r;
        end
      end else if (scl_fall) begin
        case (state_r)
          ST_ADDR: begin
            if (cnt_r == tscr_pkg::BITS_PER_BYTE) begin
              if (shift_r[7:1] == DEV_ADDR) begin
                state_r <= ST_ADDR_ACK;
                rw_r <= shift_r[0];
                sda_oe_r <= 1'b1;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            cnt_r <= 4'h0;
            first_r <= 1'b1;
            if (rw_r) begin
              state_r <= ST_READ;
              tx_r <= rd_data;
              sda_oe_r <= ~rd_data[7];
            end else begin
              state_r <= ST_WRITE;
              sda_oe_r <= 1'b0;
            end
          end
          ST_WRITE: begin
            if (cnt_r == tscr_pkg::BITS_PER_BYTE) begin
              state_r <= ST_WRITE_ACK;
              sda_oe_r <= 1'b1;
              if (first_r) begin
                ptr_r <= shift_r;
              end else begin
                wr_r.wr <= 1'b1;
                wr_r.addr <= ptr_r;
                wr_r.data <= shift_r;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          ST_WRITE_ACK: begin
            state_r <= ST_WRITE;
            sda_oe_r <= 1'b0;
            cnt_r <= 4'h0;
            first_r <= 1'b0;
          end
          ST_READ: begin
            if (cnt_r == tscr_pkg::BITS_PER_BYTE) begin
              state_r <= ST_READ_ACK;
              sda_oe_r <= 1'b0;
              ptr_r <= ptr_r + 8'h01;
            end else begin
              sda_oe_r <= ~tx_r[3'(tscr_pkg::BIT_MSB - cnt_r)];
            end
          end
          ST_READ_ACK: begin
            cnt_r <= 4'h0;
            if (nack_r) begin
              state_r <= ST_IDLE;
            end else begin
              state_r <= ST_READ;
              tx_r <= rd_data;
              sda_oe_r <= ~rd_data[7];
            end
          end
          default: begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain: the line is only ever pulled low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_out_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
    end
  end

  assign sda_out = sda_out_r;
  assign sda_oe = sda_oe_r;
  assign wr_req = wr_r;
  assign rd_addr = ptr_r;
endmodule

//--- sim/tscr_regs_props.sv
// assertions on the pins of the touch sensor register bank
`timescale 1ns/10ps
module tscr_regs_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sda_oe,
  input wire logic [3:0] touch_raw,
  input wire tscr_pkg::tscr_levels_t sens_levels,
  input wire tscr_pkg::tscr_mode_t scan_mode,
  input wire logic [7:0] ref_renew,
  input wire logic [7:0] ref_renew_strobe,
  input wire logic [7:0] channel_suspend,
  input wire logic [7:0] touch_result_low,
  input wire logic digital_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // channel 0 settles once raw level, suspend and reset are quiet
  sequence quiet0;
    (!digital_reset && !channel_suspend[0] && $stable(touch_raw[0]))[*6];
  endsequence
  rst_vals_a: assert property (digital_reset |->
    sens_levels == 12'h6DB && ref_renew == 8'h00 &&
    channel_suspend == 8'h00 && !sda_oe) else $error("reset values");
  dig_rst_a: assert property ($rose(nrst) |-> digital_reset)
    else $error("digital reset low");
  mode_reset_a: assert property (digital_reset |=>
    scan_mode == 4'h9) else $error("mode after reset");
  fast_mode_a: assert property (
    scan_mode.fast_run == scan_mode.speed_select) else $error("fast run");
  sleep_mode_a: assert property (scan_mode.sleep_run ==
    (!scan_mode.speed_select && scan_mode.sleep_enable))
    else $error("sleep run");
  result_code_a: assert property (
    touch_result_low[7] == touch_result_low[6] &&
    touch_result_low[5] == touch_result_low[4] &&
    touch_result_low[3] == touch_result_low[2] &&
    touch_result_low[1] == touch_result_low[0]) else $error("result code");
  touch_follow_a: assert property (quiet0 |->
    touch_result_low[1:0] == {2{touch_raw[0]}}) else $error("ch0 result");
  // a suspended channel keeps its last result
  suspend_hold_a: assert property (channel_suspend[1] &&
    $past(channel_suspend[1]) && !digital_reset |->
    $stable(touch_result_low[3:2])) else $error("ch1 not held");
  renew_pulse_a: assert property (ref_renew_strobe != 8'h00 |=>
    ref_renew_strobe == 8'h00 && ref_renew == $past(ref_renew_strobe))
    else $error("renew strobe");
endmodule

bind tscr_regs tscr_regs_props i_props (
  .clk(clk),
  .nrst(nrst),
  .sda_oe(sda_oe),
  .touch_raw(touch_raw),
  .sens_levels(sens_levels),
  .scan_mode(scan_mode),
  .ref_renew(ref_renew),
  .ref_renew_strobe(ref_renew_strobe),
  .channel_suspend(channel_suspend),
  .touch_result_low(touch_result_low),
  .digital_reset(digital_reset)
);

//--- sim/tscr_i2c_host.sv
// i2c host model that drives the register bank's bus pins
`timescale 1ns/10ps
module tscr_i2c_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ==========================================================
  // bus phases of six clocks, above the four-clock minimum
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic ph();
    repeat (6) @(negedge clk);
  endtask
  // sda moves one clock after scl falls, never with it
  task automatic start();
    @(negedge clk);
    sda_low = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b1;
    ph();
    scl = 1'b0;
  endtask
  task automatic stop();
    @(negedge clk);
    sda_low = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b0;
    ph();
  endtask
  // byte then ack slot; a 1 releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      @(negedge clk);
      sda_low = ~tx[i];
      ph();
      scl = 1'b1;
      ph();
      rx[i] = sda;
      scl = 1'b0;
    end
  endtask
endmodule

//--- sim/tscr_regs_tb_top.sv
// self-checking bench for the touch sensor register bank
`timescale 1ns/10ps
module tscr_regs_tb_top;
  localparam logic [6:0] DEV = 7'h2A; // value is arbitrary
  logic clk;
  logic nrst;
  logic [3:0] touch_raw;
  logic scl;
  logic h_low;
  wire sda;
  logic sda_out;
  logic sda_oe;
  tscr_pkg::tscr_levels_t sens_levels;
  tscr_pkg::tscr_mode_t scan_mode;
  logic [7:0] ref_renew;
  logic [7:0] ref_renew_strobe;
  logic [7:0] channel_suspend;
  logic [7:0] touch_result_low;
  logic digital_reset;
  int err_total;
  int cmp_count;
  logic [7:0] d;
  logic [7:0] dr_base;
  logic [7:0] strobe_or;
  logic [7:0] dr_cnt;
  logic [7:0] ofs [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
    8'h0A, 8'h30};
  logic [7:0] dflt [8] = '{8'h33, 8'h33, 8'h80, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  // open drain: low while any party pulls, else pulled up
  assign sda = ~h_low & (sda_oe ? sda_out : 1'b1);
  initial clk = 1'b0;
  always #10 clk = ~clk;
  // one-cycle outputs are gathered at the falling edge
  always @(negedge clk) begin
    if (!nrst) begin
      strobe_or <= 8'h00;
      dr_cnt <= 8'h00;
    end else begin
      strobe_or <= strobe_or | ref_renew_strobe;
      dr_cnt <= dr_cnt + {7'h00, digital_reset};
    end
  end
  tscr_i2c_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(h_low));
  tscr_regs #(.DEV_ADDR(DEV)) i_dut (
    .clk(clk),
    .nrst(nrst),
    .scl(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .touch_raw(touch_raw),
    .sens_levels(sens_levels),
    .scan_mode(scan_mode),
    .ref_renew(ref_renew),
    .ref_renew_strobe(ref_renew_strobe),
    .channel_suspend(channel_suspend),
    .touch_result_low(touch_result_low),
    .digital_reset(digital_reset)
  );
  // ==========================================================
  // checking and bus tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // data ack is not checked: a soft reset cuts it short
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    logic [8:0] r;
    logic e;
    i_host.start();
    i_host.xfer({DEV, 2'b01}, r);
    e = r[0];
    i_host.xfer({a, 1'b1}, r);
    e = e | r[0];
    i_host.xfer({v, 1'b1}, r);
    i_host.stop();
    chk(e, 1'b0);
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    logic [8:0] r;
    logic e;
    i_host.start();
    i_host.xfer({DEV, 2'b01}, r);
    e = r[0];
    i_host.xfer({a, 1'b1}, r);
    e = e | r[0];
    i_host.start();
    i_host.xfer({DEV, 2'b11}, r);
    e = e | r[0];
    i_host.xfer(9'h1FF, r);
    v = r[8:1];
    i_host.stop();
    chk(e, 1'b0);
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    end_sim();
  end
  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    touch_raw = 4'h0;
    err_total = 0;
    cmp_count = 0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      rreg(ofs[i], d);
      chk(d, dflt[i]);
    end
    chk(sens_levels, 12'h6DB);
    done("reset");
    wreg(8'h05, 8'hFF);
    rreg(8'h05, d);
    chk(d, 8'h77);
    wreg(8'h04, 8'h8C);
    rreg(8'h04, d);
    chk(d, 8'h04);
    chk(sens_levels, 12'hFC4);
    done("levels");
    wreg(8'h06, 8'h7F);
    wreg(8'h07, 8'hF7);
    chk(scan_mode, 4'h6);
    rreg(8'h06, d);
    chk(d, 8'h00);
    rreg(8'h07, d);
    chk(d, 8'h04);
    wreg(8'h06, 8'h80);
    chk(scan_mode, 4'hD);
    done("mode");
    wreg(8'h08, 8'hA5);
    chk(strobe_or, 8'hA5);
    rreg(8'h08, d);
    chk(d, 8'hA5);
    chk(ref_renew, 8'hA5);
    touch_raw = 4'hA;
    repeat (8) @(negedge clk);
    chk(touch_result_low, 8'hCC);
    wreg(8'h0A, 8'hFF);
    rreg(8'h0A, d);
    chk(d, 8'hCC);
    wreg(8'h09, 8'h02);
    chk(channel_suspend, 8'h02);
    touch_raw = 4'h5;
    repeat (8) @(negedge clk);
    chk(touch_result_low, 8'h3F);
    rreg(8'h09, d);
    chk(d, 8'h02);
    done("touch");
    dr_base = dr_cnt;
    wreg(8'h07, 8'h0C);
    repeat (4) @(negedge clk);
    chk(dr_cnt - dr_base, 12'h001);
    chk(scan_mode, 4'h9);
    rreg(8'h07, d);
    chk(d, 8'h00);
    rreg(8'h05, d);
    chk(d, 8'h33);
    chk(ref_renew, 8'h00);
    chk(touch_result_low, 8'h33);
    done("soft reset");
    end_sim();
  end
endmodule
